//--- core/ldfm_cfg.svh
// Constants for the loop DAC fault monitor: codes, bit positions, timing
`ifndef LDFM_CFG_SVH
`define LDFM_CFG_SVH

// Command bytes
`define LDFM_CMD_WR_DAC    8'h01
`define LDFM_CMD_WR_CTRL   8'h02
`define LDFM_CMD_ADC_CONV  8'h08
`define LDFM_CMD_RD_CTRL   8'h82
`define LDFM_CMD_RD_FAULT  8'h85

// Frame shape
`define LDFM_FRAME_BITS    5'h18
`define LDFM_CMD_HI        23
`define LDFM_CMD_LO        16

// Control word bits
`define LDFM_CTRL_WDOG_DIS 2
`define LDFM_CTRL_ADC_ON   7
`define LDFM_CTRL_ADC_SEL  8
`define LDFM_CTRL_NO_AUTO  11
`define LDFM_CTRL_RESET    16'h0000
`define LDFM_DAC_RESET     16'h0000

// Fault word bits
`define LDFM_FLT_SPI       15
`define LDFM_FLT_T140      11
`define LDFM_FLT_T100      10
`define LDFM_FLT_CRIT      9
`define LDFM_FLT_LOW       8

// Range straps {hi, lo} selecting the widest span
`define LDFM_RANGE_WIDE    2'b10

// Watchdog timing
`define LDFM_CLK_HZ        100000000
`define LDFM_WDOG_TIME_MS  1000

`endif

//--- core/ldfm_pkg.sv
// Types shared by the loop DAC fault monitor
`default_nettype none

package ldfm_pkg;

	typedef enum logic [1:0]
	{
		ALARM_3P2,
		ALARM_22P8,
		ALARM_24
	} ldfm_alarm_t;

	typedef enum logic [0:0]
	{
		ADC_IDLE,
		ADC_WAIT
	} ldfm_adc_state_t;

endpackage : ldfm_pkg

`default_nettype wire

//--- core/ldfm_monitor.sv
// Fault flags, alert pin, ADC control, watchdog and power-on alarm
`default_nettype none
`include "ldfm_cfg.svh"

module ldfm_monitor #(
	parameter int ADC_W       = 8,
	parameter int WDOG_W      = 27,
	parameter int WDOG_CYCLES = `LDFM_CLK_HZ / 1000 * `LDFM_WDOG_TIME_MS
) (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic                  sclk,
	input  wire logic                  sync_n,
	input  wire logic                  sdin,
	output var  logic                  sdo,
	input  wire logic                  temp_above_100,
	input  wire logic                  temp_above_140,
	input  wire logic                  loop_below_0p6,
	input  wire logic                  loop_above_0p7,
	input  wire logic                  loop_below_0p3,
	input  wire logic                  loop_above_0p4,
	input  wire logic                  range_sel_lo,
	input  wire logic                  range_sel_hi,
	input  wire logic                  alarm_polarity,
	input  wire logic                  adc_done,
	input  wire logic [ADC_W-1:0]      adc_data,
	output var  logic                  adc_power,
	output var  logic                  adc_source,
	output var  logic                  adc_start,
	output var  logic                  alert,
	output var  logic                  alarm_force,
	output var  ldfm_pkg::ldfm_alarm_t alarm_level,
	output var  logic [15:0]           loop_code
);
	import ldfm_pkg::*;

	localparam int NPIN = 12;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [NPIN-1:0] pin_s1_reg;
	logic [NPIN-1:0] pin_s2_reg;
	logic            sclk_d_reg;
	logic            sync_d_reg;

	always_ff @(posedge clk)
	begin
		pin_s1_reg <= {alarm_polarity, range_sel_hi, range_sel_lo,
			loop_above_0p4, loop_below_0p3, loop_above_0p7, loop_below_0p6,
			temp_above_140, temp_above_100, sdin, sync_n, sclk};
		pin_s2_reg <= pin_s1_reg;
		sclk_d_reg <= pin_s2_reg[0];
		sync_d_reg <= pin_s2_reg[1];
	end

	logic sclk_s;
	logic sync_s;
	logic sdin_s;
	assign sclk_s = pin_s2_reg[0];
	assign sync_s = pin_s2_reg[1];
	assign sdin_s = pin_s2_reg[2];

	// Link edges as seen by the local clock
	logic sclk_fall;
	logic sclk_rise;
	logic frame_open;
	logic frame_close;
	assign sclk_fall   = sclk_d_reg & ~sclk_s & ~sync_s;
	assign sclk_rise   = ~sclk_d_reg & sclk_s & ~sync_s;
	assign frame_open  = sync_d_reg & ~sync_s;
	assign frame_close = ~sync_d_reg & sync_s;

	////////////////////////////////////////////////////////////////////////
	// Fault flags

	logic                  t100_reg;
	logic                  t140_reg;
	logic                  low_reg;
	logic                  crit_reg;
	logic                  spi_fault_reg;
	logic [ADC_W-1:0]      adc_result_reg;

	function automatic logic [15:0] fault_word(
		input logic             spi_f,
		input logic             t140,
		input logic             t100,
		input logic             crit,
		input logic             low,
		input logic [ADC_W-1:0] result
	);
		logic [15:0] w;
		w = 16'h0000;
		w[ADC_W-1:0]      = result;
		w[`LDFM_FLT_SPI]  = spi_f;
		w[`LDFM_FLT_T140] = t140;
		w[`LDFM_FLT_T100] = t100;
		w[`LDFM_FLT_CRIT] = crit;
		w[`LDFM_FLT_LOW]  = low;
		return w;
	endfunction : fault_word

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			t100_reg <= 1'b0;
			t140_reg <= 1'b0;
		end
		else
		begin
			t100_reg <= pin_s2_reg[3];
			t140_reg <= pin_s2_reg[4];
		end
	end

	// Hysteresis: a fall below the low threshold wins over a clear
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			low_reg  <= 1'b0;
			crit_reg <= 1'b0;
		end
		else
		begin
			if (pin_s2_reg[5])
				low_reg <= 1'b1;
			else if (pin_s2_reg[6])
				low_reg <= 1'b0;
			if (pin_s2_reg[7])
				crit_reg <= 1'b1;
			else if (pin_s2_reg[8])
				crit_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial frame receive and readback

	logic [23:0] rx_reg;
	logic [4:0]  bit_cnt_reg;
	logic [23:0] tx_reg;
	logic [15:0] ctrl_reg;
	logic [15:0] resp_reg;
	logic        frame_ok;
	logic [7:0]  cmd;
	logic [15:0] data;

	assign frame_ok = frame_close && bit_cnt_reg == `LDFM_FRAME_BITS;
	assign cmd      = rx_reg[`LDFM_CMD_HI:`LDFM_CMD_LO];
	assign data     = rx_reg[15:0];

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rx_reg      <= 24'h00_0000;
			bit_cnt_reg <= 5'h00;
		end
		else if (frame_open)
			bit_cnt_reg <= 5'h00;
		else if (sclk_fall)
		begin
			rx_reg <= {rx_reg[22:0], sdin_s};
			if (bit_cnt_reg != 5'h1f)
				bit_cnt_reg <= bit_cnt_reg + 5'h01;
		end
	end

	// Word clocked out in the frame after the one that asked for it
	always_ff @(posedge clk)
	begin
		if (reset)
			resp_reg <= 16'h0000;
		else if (frame_ok)
		begin
			if (!ctrl_reg[`LDFM_CTRL_NO_AUTO] || cmd == `LDFM_CMD_RD_FAULT)
				resp_reg <= fault_word(spi_fault_reg, t140_reg, t100_reg,
					crit_reg, low_reg, adc_result_reg);
			else if (cmd == `LDFM_CMD_RD_CTRL)
				resp_reg <= ctrl_reg;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			tx_reg <= 24'h00_0000;
			sdo    <= 1'b0;
		end
		else if (frame_open)
		begin
			tx_reg <= {8'h00, resp_reg};
			sdo    <= 1'b0;
		end
		else if (sclk_rise)
		begin
			sdo    <= tx_reg[23];
			tx_reg <= {tx_reg[22:0], 1'b0};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control and DAC registers

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ctrl_reg  <= `LDFM_CTRL_RESET;
			loop_code <= `LDFM_DAC_RESET;
		end
		else if (frame_ok)
		begin
			if (cmd == `LDFM_CMD_WR_CTRL)
				ctrl_reg <= data;
			if (cmd == `LDFM_CMD_WR_DAC)
				loop_code <= data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Watchdog

	logic [WDOG_W-1:0] wdog_cnt_reg;
	logic              wdog_hit;
	logic              fault_read;

	assign wdog_hit   = !ctrl_reg[`LDFM_CTRL_WDOG_DIS] && !spi_fault_reg
		&& !frame_ok && wdog_cnt_reg == WDOG_W'(WDOG_CYCLES - 1);
	// With auto readback every frame returns the fault word
	assign fault_read = frame_ok && (cmd == `LDFM_CMD_RD_FAULT
		|| !ctrl_reg[`LDFM_CTRL_NO_AUTO]);

	// Counting is frozen while the fault stands, until it is read
	always_ff @(posedge clk)
	begin
		if (reset || frame_ok)
			wdog_cnt_reg <= '0;
		else if (!ctrl_reg[`LDFM_CTRL_WDOG_DIS] && !spi_fault_reg
			&& !wdog_hit)
			wdog_cnt_reg <= wdog_cnt_reg + WDOG_W'(1);
		else if (wdog_hit)
			wdog_cnt_reg <= '0;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			spi_fault_reg <= 1'b0;
		else if (wdog_hit)
			spi_fault_reg <= 1'b1;
		else if (fault_read)
			spi_fault_reg <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Alarm current and alert pin

	always_ff @(posedge clk)
	begin
		if (reset)
			alarm_force <= 1'b1;
		else if (wdog_hit)
			alarm_force <= 1'b1;
		else if (frame_ok && cmd == `LDFM_CMD_WR_DAC && !spi_fault_reg)
			alarm_force <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			alarm_level <= ALARM_3P2;
		else if (!pin_s2_reg[11])
			alarm_level <= ALARM_3P2;
		else if ({pin_s2_reg[10], pin_s2_reg[9]} == `LDFM_RANGE_WIDE)
			alarm_level <= ALARM_24;
		else
			alarm_level <= ALARM_22P8;
	end

	// Low-threshold flags stay out of the pin on purpose
	always_ff @(posedge clk)
	begin
		if (reset)
			alert <= 1'b0;
		else
			alert <= t140_reg | crit_reg | spi_fault_reg;
	end

	////////////////////////////////////////////////////////////////////////
	// On-chip ADC control

	ldfm_adc_state_t adc_state_reg;
	logic            conv_req;

	// Auto readback with the ADC on converts after every accepted frame
	assign conv_req = frame_ok && (cmd == `LDFM_CMD_ADC_CONV
		|| (ctrl_reg[`LDFM_CTRL_ADC_ON]
		&& !ctrl_reg[`LDFM_CTRL_NO_AUTO]));

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			adc_state_reg  <= ADC_IDLE;
			adc_start      <= 1'b0;
			adc_result_reg <= '0;
		end
		else
		begin
			adc_start <= 1'b0;
			case (adc_state_reg)
				ADC_IDLE:
				begin
					if (conv_req)
					begin
						adc_start     <= 1'b1;
						adc_state_reg <= ADC_WAIT;
					end
				end
				ADC_WAIT:
				begin
					if (adc_done)
					begin
						adc_result_reg <= adc_data;
						adc_state_reg  <= ADC_IDLE;
					end
				end
				default:
					adc_state_reg <= ADC_IDLE;
			endcase
		end
	end

	// A single conversion keeps the converter powered until it finishes
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			adc_power  <= 1'b0;
			adc_source <= 1'b0;
		end
		else
		begin
			adc_power  <= ctrl_reg[`LDFM_CTRL_ADC_ON] || conv_req
				|| adc_state_reg == ADC_WAIT;
			adc_source <= ctrl_reg[`LDFM_CTRL_ADC_SEL];
		end
	end

endmodule : ldfm_monitor

`default_nettype wire

//--- tb/ldfm_properties.sv
// Port-level assertions for the loop DAC fault monitor
`default_nettype none

module ldfm_properties
	import ldfm_pkg::*;
#(
	parameter int WDOG_CYCLES = 2000
) (
	input wire logic                  clk,
	input wire logic                  reset,
	input wire logic                  sync_n,
	input wire logic                  temp_above_140,
	input wire logic                  loop_below_0p3,
	input wire logic                  loop_above_0p4,
	input wire logic                  range_sel_lo,
	input wire logic                  range_sel_hi,
	input wire logic                  alarm_polarity,
	input wire logic                  adc_start,
	input wire logic                  adc_power,
	input wire logic                  alert,
	input wire logic                  alarm_force,
	input wire ldfm_pkg::ldfm_alarm_t alarm_level,
	input wire logic [15:0]           loop_code
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	// Quiet time since reset or a frame; the margin covers synchroniser lag
	int quiet_cnt;
	always_ff @(posedge clk)
	begin
		if (reset || !sync_n)
			quiet_cnt <= 0;
		else if (quiet_cnt < WDOG_CYCLES + 8)
			quiet_cnt <= quiet_cnt + 1;
	end

	////////////////////////////////////////////////////////////////////
	a_reset_state:
		assert property (disable iff (1'b0) reset |=> alarm_force && !alert
			&& loop_code == 16'h0000 && alarm_level == ALARM_3P2)
		else $error("reset state wrong");
	a_hot_alert:
		assert property (temp_above_140 [*6] |-> alert)
		else $error("hot die without alert");
	a_crit_alert:
		assert property (loop_below_0p3 [*6] |-> alert)
		else $error("critical supply without alert");
	a_quiet_alert:
		assert property ((!temp_above_140 && !loop_below_0p3 && loop_above_0p4
			&& !alarm_force) [*6] |-> !alert)
		else $error("alert with no cause");
	a_flag_sync:
		assert property ($rose(temp_above_140) && !alert |=> !alert)
		else $error("comparator reached alert unsynchronised");
	a_start_pulse:
		assert property (adc_start |-> adc_power ##1 !adc_start)
		else $error("conversion start malformed");
	a_alarm_down:
		assert property (!alarm_polarity [*6] |-> alarm_level == ALARM_3P2)
		else $error("downscale alarm level wrong");
	a_alarm_up:
		assert property ((alarm_polarity
			&& $stable({range_sel_hi, range_sel_lo})) [*6] |-> alarm_level ==
			({range_sel_hi, range_sel_lo} == 2'b10 ? ALARM_24 : ALARM_22P8))
		else $error("upscale alarm level wrong");
	a_wdog_fault:
		assert property (quiet_cnt == WDOG_CYCLES + 8 |-> alert && alarm_force)
		else $error("watchdog timeout not flagged");

	cover property (adc_start);
	cover property ($rose(alert));
	cover property ($fell(alarm_force));
endmodule : ldfm_properties

bind ldfm_monitor ldfm_properties #(.WDOG_CYCLES(WDOG_CYCLES)) ldfm_prop_i (
	.clk, .reset, .sync_n, .temp_above_140, .loop_below_0p3,
	.loop_above_0p4, .range_sel_lo, .range_sel_hi, .alarm_polarity,
	.adc_start, .adc_power, .alert, .alarm_force, .alarm_level, .loop_code
);

`default_nettype wire

//--- tb/ldfm_host.sv
// Host serial master model for the monitor's frame pins
`default_nettype none

module ldfm_host (
	output var logic sclk,
	output var logic sync_n,
	output var logic sdin,
	input wire logic sdo
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		sclk = 1'b1;
		sync_n = 1'b1;
		sdin = 1'b0;
	end

	// One 24-bit frame MSB first; resp gets what the device shifts out
	task automatic xfer(
		input  logic [7:0]  cmd,
		input  logic [15:0] data,
		output logic [23:0] resp
	);
		logic [23:0] word;
		word = {cmd, data};
		resp = 24'h00_0000;
		sync_n = 1'b0;
		#125;
		for (int i = 23; i >= 0; i--)
		begin
			sdin = word[i];
			#62.5;
			// Device moves sdo after each rise, so bit i+1 stands here
			if (i < 23)
				resp[i + 1] = sdo;
			sclk = 1'b0;
			#62.5;
			sclk = 1'b1;
		end
		#62.5;
		resp[0] = sdo;
		sync_n = 1'b1;
		// Released line flips so a stale bit can never look valid
		sdin = ~sdin;
		#250;
	endtask : xfer
endmodule : ldfm_host

`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the loop DAC fault monitor
`default_nettype none

module tb_top
	import ldfm_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int WDOG = 2000;
	logic clk, reset, sclk, sync_n, sdin, sdo, adc_done, adc_power;
	logic temp_above_100, temp_above_140, loop_below_0p6, loop_above_0p7;
	logic loop_below_0p3, loop_above_0p4, range_sel_lo, range_sel_hi;
	logic alarm_polarity, adc_source, adc_start, alert, alarm_force;
	logic [7:0]  adc_data;
	logic [15:0] loop_code;
	logic [23:0] resp;
	ldfm_alarm_t alarm_level;
	int          mismatches = 0;
	int          checked = 0;
	int          cycles = 0;
	int          starts = 0;

	ldfm_monitor #(.WDOG_CYCLES(WDOG)) ldfm_monitor_i (
		.clk, .reset, .sclk, .sync_n, .sdin, .sdo, .temp_above_100,
		.temp_above_140, .loop_below_0p6, .loop_above_0p7, .loop_below_0p3,
		.loop_above_0p4, .range_sel_lo, .range_sel_hi, .alarm_polarity,
		.adc_done, .adc_data, .adc_power, .adc_source, .adc_start, .alert,
		.alarm_force, .alarm_level, .loop_code
	);
	ldfm_host ldfm_host_i (.sclk, .sync_n, .sdin, .sdo);

	////////////////////////////////////////////////////////////////////
	task automatic check(input logic [23:0] seen, input logic [23:0] want);
		checked++;
		if (seen !== want)
		begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, want);
		end
	endtask : check

	task automatic stop_test;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test

	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask : idle

	// With auto readback on, the second frame returns the first's status
	task automatic nop2;
		ldfm_host_i.xfer(8'h00, 16'h0000, resp);
		ldfm_host_i.xfer(8'h00, 16'h0000, resp);
		// Frames end off the clock grid; realign to a falling edge
		idle(1);
	endtask : nop2

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			stop_test();
		end
	end

	// Converter stand-in answers each start a few cycles later
	always @(posedge adc_start)
	begin
		starts++;
		idle(5);
		adc_done = 1'b1;
		idle(1);
		adc_done = 1'b0;
	end

	initial
	begin
		reset = 1'b1;
		{temp_above_100, temp_above_140, loop_below_0p6, loop_below_0p3} = '0;
		{loop_above_0p7, loop_above_0p4} = 2'b11;
		{range_sel_hi, range_sel_lo, alarm_polarity} = 3'b001;
		adc_done = 1'b0;
		adc_data = 8'hA5;
		idle(4);
		reset = 1'b0;
		check({alarm_force, loop_code}, {1'b1, 16'h0000});
		check(alarm_level, ALARM_3P2);
		for (int r = 0; r < 3; r++)
		begin
			{range_sel_hi, range_sel_lo} = r[1:0];
			idle(8);
			check(alarm_level, r == 2 ? ALARM_24 : ALARM_22P8);
		end
		alarm_polarity = 1'b0;
		idle(WDOG);
		check(alarm_level, ALARM_3P2);
		check({alert, alarm_force}, 2'b11);
		ldfm_host_i.xfer(8'h85, 16'h0000, resp);
		ldfm_host_i.xfer(8'h01, 16'h1234, resp);
		check(resp[15], 1'b1);
		idle(6);
		check({alert, alarm_force, loop_code}, {2'b00, 16'h1234});
		temp_above_100 = 1'b1;
		idle(10);
		check(alert, 1'b0);
		temp_above_140 = 1'b1;
		idle(10);
		check(alert, 1'b1);
		nop2();
		check(resp[11:10], 2'b11);
		{temp_above_100, temp_above_140} = 2'b00;
		idle(10);
		check(alert, 1'b0);
		{loop_below_0p6, loop_above_0p7} = 2'b10;
		idle(10);
		check(alert, 1'b0);
		{loop_below_0p3, loop_above_0p4} = 2'b10;
		idle(10);
		check(alert, 1'b1);
		loop_below_0p3 = 1'b0;
		idle(10);
		check(alert, 1'b1);
		loop_above_0p4 = 1'b1;
		idle(10);
		check(alert, 1'b0);
		loop_below_0p6 = 1'b0;
		nop2();
		check(resp[9:8], 2'b01);
		loop_above_0p7 = 1'b1;
		nop2();
		check(resp[9:8], 2'b00);
		ldfm_host_i.xfer(8'h02, 16'h0900, resp);
		idle(6);
		check(adc_source, 1'b1);
		ldfm_host_i.xfer(8'h82, 16'h0000, resp);
		ldfm_host_i.xfer(8'h08, 16'h0000, resp);
		check(resp[15:0], 16'h0900);
		ldfm_host_i.xfer(8'h85, 16'h0000, resp);
		ldfm_host_i.xfer(8'h00, 16'h0000, resp);
		check(resp[7:0], 8'hA5);
		check(adc_power, 1'b0);
		check(24'(starts), 24'h00_0001);
		idle(1);
		adc_data = 8'h3C;
		ldfm_host_i.xfer(8'h02, 16'h0080, resp);
		idle(1500);
		ldfm_host_i.xfer(8'h00, 16'h0000, resp);
		// Link is left quiet for 15 us, short of the watchdog, after going back to temperature
		idle(1500);
		check(alert, 1'b0);
		check({adc_power, adc_source}, 2'b10);
		nop2();
		check(resp[7:0], 8'h3C);
		check(24'(starts), 24'h00_0004);
		idle(10);
		reset = 1'b1;
		idle(4);
		reset = 1'b0;
		check({alarm_force, alert, adc_power}, 3'b100);
		check(loop_code, 16'h0000);
		stop_test();
	end
endmodule : tb_top

`default_nettype wire
